// File: chanpol_regs.svh
// Register offsets, field positions and reset values of the channel polarity and counter block
//
// Contract
// - In output mode the complementary polarity bit makes the complementary output active high at 0 and active low at 1.
// - In output mode the main polarity bit makes the channel output active high at 0 and active low at 1.
// - In input mode with both polarity bits clear the rising edge is active and the input passes uninverted.
// - In input mode with only the main polarity bit set the falling edge is active and the input is inverted.
// - In input mode with both polarity bits set both edges are active and the input is not inverted.
// - The enable bit at position 0 disables the channel at 0 and enables its capture or compare function at 1.
// - Reading the counter register returns the 16-bit count in bits 15 to 0 and a full-word write loads the counter.
// - After reset the counter register reads as zero.
// - The two-bit role field selects output at 00 and input from the filtered channel input at 01, others reserved.
// - The input-capture edge prescaler is held in reset while the channel enable bit is clear.
`ifndef CHANPOL_REGS_SVH
`define CHANPOL_REGS_SVH

`define OFS_ROLE_CTRL 8'h18
`define OFS_ENABLE_POL 8'h20
`define OFS_COUNTER 8'h24
`define OFS_RUN_CTRL 8'h00

`define BIT_FUNC_EN 0
`define BIT_MAIN_POL 1
`define BIT_COMPL_POL 3
`define BIT_RUN 0
`define ROLE_LSB 0
`define ROLE_MSB 1
`define PSC_LSB 2
`define PSC_MSB 3
`define ROLE_OUTPUT 2'h0
`define ROLE_INPUT 2'h1

`define ENPOL_MASK 32'h0000_000B
`define ROLE_MASK 32'h0000_000F
`define RUN_MASK 32'h0000_0001
`define CNT_MASK 32'h0000_FFFF
`define RESET_WORD 32'h0000_0000
`define CNT_RESET 16'h0000
`define CNT_ONE 16'h0001
`define EDGES_RESET 3'h0
`define EDGES_STEP 3'h1
`define EDGES_DIV1 3'h0
`define EDGES_DIV2 3'h1
`define EDGES_DIV4 3'h3
`define EDGES_DIV8 3'h7
`define CNT_MSB 15
`define CNT_LSB 0
`define ZERO_WORD 32'h0000_0000

`endif

// File: chanpol_pkg.sv
// Types shared by the channel polarity and counter block
package chanpol_pkg;
  typedef struct packed {
    logic compl_pol;
    logic main_pol;
    logic func_en;
  } enpol_t;

  typedef struct packed {
    logic [1:0] psc;
    logic [1:0] role;
  } role_t;

  typedef struct packed {
    logic active_edge;
    logic polar_level;
  } edge_info_t;
endpackage

// File: edge_polarity.sv
// Polarity select and active-edge detection of the filtered channel input
`timescale 1ns/1ps
module edge_polarity (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Control
  input wire chanpol_pkg::enpol_t enpol,
  input wire logic input_role,
  // Filtered channel input
  input wire logic chan_filtered_input,
  // Result
  output chanpol_pkg::edge_info_t info
);
  import chanpol_pkg::*;

  logic prev_r;
  wire rise = chan_filtered_input & ~prev_r;
  wire fall = ~chan_filtered_input & prev_r;
  wire both_sel = enpol.compl_pol & enpol.main_pol;
  wire fall_sel = ~enpol.compl_pol & enpol.main_pol;
  wire rise_sel = ~enpol.compl_pol & ~enpol.main_pol;
  wire edge_hit = (rise_sel & rise) |
                  (fall_sel & fall) |
                  (both_sel & (rise | fall));
  wire level = fall_sel ? ~chan_filtered_input : chan_filtered_input;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      prev_r <= 1'b0;
      info <= '0;
    end else begin
      prev_r <= chan_filtered_input;
      info.polar_level <= level;
      info.active_edge <= edge_hit & input_role & enpol.func_en;
    end
  end
endmodule // edge_polarity

// File: capture_prescaler.sv
// Input-capture edge prescaler
`timescale 1ns/1ps
`include "chanpol_regs.svh"
module capture_prescaler (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Control
  input wire logic enable,
  input wire logic [1:0] psc,
  // Edges
  input wire logic edge_in,
  output logic capture_pulse
);
  logic [2:0] edges_r;
  wire [2:0] limit = (psc == 2'h0) ? `EDGES_DIV1 : (psc == 2'h1) ? `EDGES_DIV2 :
                     (psc == 2'h2) ? `EDGES_DIV4 : `EDGES_DIV8;
  wire wrap = edge_in & (edges_r == limit);

  always_ff @(posedge mclk) begin
    if (!resetn || !enable) begin
      edges_r <= `EDGES_RESET;
      capture_pulse <= 1'b0;
    end else begin
      capture_pulse <= wrap;
      if (edge_in) begin
        edges_r <= wrap ? `EDGES_RESET : edges_r + `EDGES_STEP;
      end
    end
  end
endmodule // capture_prescaler

// File: timer_channel_polarity_counter.sv
// Channel 0 polarity, enable and counter registers with an Avalon-MM slave
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ps
`include "chanpol_regs.svh"
module timer_channel_polarity_counter (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Channel side
  input wire logic chan_filtered_input,
  input wire logic compare_active,
  output logic chan_output_pin,
  output logic chan_compl_output,
  output logic capture_event,
  output logic input_level,
  output logic [15:0] count_value
);
  import chanpol_pkg::*;

  enpol_t enpol_r;
  role_t role_r;
  logic run_r;
  logic [15:0] count_r;
  logic ack_r;
  logic [31:0] rdata_r;
  edge_info_t info;

  // One wait state per access
  wire req = avs_read | avs_write;
  wire take = req & ack_r;
  wire full_word = (avs_byteenable == 4'hF);
  wire wr = avs_write & take & full_word;
  wire hit_enpol = (avs_address == `OFS_ENABLE_POL);
  wire hit_role = (avs_address == `OFS_ROLE_CTRL);
  wire hit_cnt = (avs_address == `OFS_COUNTER);
  wire hit_run = (avs_address == `OFS_RUN_CTRL);
  wire input_role = (role_r.role == `ROLE_INPUT);
  wire output_role = (role_r.role == `ROLE_OUTPUT);

  wire [31:0] rd_mux;
  assign rd_mux = hit_enpol ? {28'h000_0000, enpol_r.compl_pol, 1'b0,
                               enpol_r.main_pol, enpol_r.func_en} :
                  hit_role ? {28'h000_0000, role_r} :
                  hit_cnt ? {16'h0000, count_r} :
                  hit_run ? {31'h0000_0000, run_r} :
                  `ZERO_WORD;

  assign avs_waitrequest = req & ~ack_r;
  assign avs_readdata = rdata_r;
  assign count_value = count_r;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ack_r <= 1'b0;
      rdata_r <= `ZERO_WORD;
    end else begin
      ack_r <= req & ~ack_r;
      rdata_r <= (avs_read & ~ack_r) ? rd_mux : rdata_r;
    end
  end

  // Control registers; reserved bits are not stored
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      enpol_r <= '0;
      role_r <= '0;
      run_r <= 1'b0;
    end else if (wr) begin
      if (hit_enpol) begin
        enpol_r.func_en <= avs_writedata[`BIT_FUNC_EN];
        enpol_r.main_pol <= avs_writedata[`BIT_MAIN_POL];
        enpol_r.compl_pol <= avs_writedata[`BIT_COMPL_POL];
      end else if (hit_role) begin
        role_r.psc <= avs_writedata[`PSC_MSB:`PSC_LSB];
        if (!enpol_r.func_en) begin
          role_r.role <= avs_writedata[`ROLE_MSB:`ROLE_LSB];
        end
      end else if (hit_run) begin
        run_r <= avs_writedata[`BIT_RUN];
      end
    end
  end

  // Counter
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      count_r <= `CNT_RESET;
    end else if (wr && hit_cnt) begin
      count_r <= avs_writedata[`CNT_MSB:`CNT_LSB];
    end else if (run_r) begin
      count_r <= count_r + `CNT_ONE;
    end
  end

  // Output polarity
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      chan_output_pin <= 1'b0;
      chan_compl_output <= 1'b0;
    end else begin
      chan_output_pin <= (output_role & enpol_r.func_en) ?
                         (compare_active ^ enpol_r.main_pol) : 1'b0;
      chan_compl_output <= (output_role & enpol_r.func_en) ?
                           (~compare_active ^ enpol_r.compl_pol) : 1'b0;
    end
  end

  edge_polarity u_edge (
    .mclk(mclk),
    .resetn(resetn),
    .enpol(enpol_r),
    .input_role(input_role),
    .chan_filtered_input(chan_filtered_input),
    .info(info)
  );

  capture_prescaler u_psc (
    .mclk(mclk),
    .resetn(resetn),
    .enable(enpol_r.func_en),
    .psc(role_r.psc),
    .edge_in(info.active_edge),
    .capture_pulse(capture_event)
  );

  assign input_level = info.polar_level;
endmodule // timer_channel_polarity_counter

// File: tcpc_props.sv
// Port assertions for the channel polarity and counter block
`timescale 1ns/1ps
module tcpc_props (
  // Clock, reset and bus
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Channel side
  input wire logic chan_filtered_input,
  input wire logic compare_active,
  input wire logic chan_output_pin,
  input wire logic chan_compl_output,
  input wire logic capture_event,
  input wire logic input_level,
  input wire logic [15:0] count_value
);
  logic [3:0] pol_r;
  logic [3:0] role_r;
  wire wr_ok = avs_write && !avs_waitrequest && avs_byteenable == 4'hF;
  wire [15:0] wd_lo = avs_writedata[15:0];
  wire en_p = pol_r[0];
  wire main_p = pol_r[1];
  wire compl_p = pol_r[3];
  wire out_on = en_p && role_r[1:0] == 2'h0;
  wire in_on = en_p && role_r[1:0] == 2'h1;
  wire psc0 = role_r[3:2] == 2'h0;
  // Shadow copies of the enable/polarity and role control registers
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pol_r <= 4'h0;
      role_r <= 4'h0;
    end else begin
      if (wr_ok && avs_address == 8'h20) pol_r <= avs_writedata[3:0] & 4'hB;
      if (wr_ok && avs_address == 8'h18 && !en_p) role_r <= avs_writedata[3:0];
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  a_rd_count: assert property (avs_read && !avs_waitrequest && avs_address == 8'h24 |->
    avs_readdata[31:16] == 16'h0000 && (avs_readdata[15:0] == count_value ||
    avs_readdata[15:0] == $past(count_value))) else $error("counter read wrong");
  a_wr_count: assert property (wr_ok && avs_address == 8'h24 |=>
    count_value == $past(wd_lo)) else $error("counter load wrong");
  a_cnt_reset: assert property ($rose(resetn) |-> count_value == 16'h0000)
    else $error("counter not zero after reset");
  a_main_pol: assert property (out_on |=>
    chan_output_pin == ($past(compare_active) ^ $past(main_p))) else $error("output level wrong");
  a_compl_pol: assert property (out_on |=>
    chan_compl_output == (!$past(compare_active) ^ $past(compl_p))) else $error("compl level wrong");
  a_off_quiet: assert property (!en_p |=> !chan_output_pin && !chan_compl_output)
    else $error("outputs active while off");
  a_in_level: assert property (in_on |=> input_level ==
    ($past(chan_filtered_input) ^ ($past(main_p) && !$past(compl_p)))) else $error("level wrong");
  a_cap_rise: assert property (in_on && psc0 && !main_p && !compl_p &&
    $rose(chan_filtered_input) |-> ##[1:3] capture_event) else $error("rising edge missed");
  a_cap_fall: assert property (in_on && psc0 && main_p &&
    $fell(chan_filtered_input) |-> ##[1:3] capture_event) else $error("falling edge missed");
  a_cap_off: assert property ((!en_p) [*3] |-> !capture_event)
    else $error("capture while off");
  c_read: cover property (avs_read && !avs_waitrequest);
  c_cap: cover property (capture_event);
  c_out: cover property (chan_output_pin && chan_compl_output);
endmodule // tcpc_props
bind timer_channel_polarity_counter tcpc_props i_props (
  .mclk(mclk),
  .resetn(resetn),
  .avs_address(avs_address),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .chan_filtered_input(chan_filtered_input),
  .compare_active(compare_active),
  .chan_output_pin(chan_output_pin),
  .chan_compl_output(chan_compl_output),
  .capture_event(capture_event),
  .input_level(input_level),
  .count_value(count_value)
);

// File: timer_channel_polarity_counter_test.sv
// Self-checking bench for the channel polarity and counter block
`timescale 1ns/1ps
module timer_channel_polarity_counter_test;
  logic mclk, resetn, avs_read, avs_write, avs_waitrequest, chan_filtered_input;
  logic compare_active, chan_output_pin, chan_compl_output, capture_event, input_level;
  logic [7:0] avs_address;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [15:0] count_value;
  logic [3:0] mode [7] = '{4'h1, 4'h3, 4'hB, 4'h0, 4'hB, 4'hB, 4'hB};
  logic [3:0] rol [7] = '{4'h1, 4'h1, 4'h1, 4'h1, 4'h5, 4'h9, 4'hD};
  int ncx [7] = '{2, 2, 4, 0, 2, 1, 0};
  int err_total = 0, n_compared = 0, cyc = 0, ncap = 0, base = 0;
  timer_channel_polarity_counter i_dut (
    .mclk(mclk),
    .resetn(resetn),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .chan_filtered_input(chan_filtered_input),
    .compare_active(compare_active),
    .chan_output_pin(chan_output_pin),
    .chan_compl_output(chan_compl_output),
    .capture_event(capture_event),
    .input_level(input_level),
    .count_value(count_value)
  );
  task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task wrap_up;
    $display("compared %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d,
           input logic [3:0] be = 4'hF);
    @(posedge mclk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    avs_byteenable <= be;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (capture_event === 1'b1) ncap <= ncap + 1;
    if (cyc == 2000) begin
      err_total++;
      wrap_up;
    end
  end
  initial begin
    {resetn, avs_read, avs_write, chan_filtered_input, compare_active} = 5'h0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    acc(0, 8'h24, 0); chk("cnt_reset", q, 0);
    acc(0, 8'h40, 0); chk("unmapped", q, 0);
    acc(1, 8'h24, 32'hFFFF_1234); acc(0, 8'h24, 0); chk("cnt_load", q, 32'h1234);
    acc(1, 8'h24, 32'h5555, 4'h3); acc(0, 8'h24, 0); chk("cnt_half", q, 32'h1234);
    acc(1, 8'h00, 1); acc(1, 8'h24, 32'h0F00); acc(1, 8'h00, 0);
    acc(0, 8'h24, 0); chk("cnt_run", q, 32'h0F03);
    for (int i = 0; i < 8; i++) begin
      acc(1, 8'h20, {28'h0, i[2], 1'b0, i[1], 1'b1});
      compare_active <= i[0];
      repeat (3) @(posedge mclk);
      chk("out", chan_output_pin, i[0] ^ i[1]);
      chk("outn", chan_compl_output, !i[0] ^ i[2]);
    end
    acc(1, 8'h20, 0); repeat (2) @(posedge mclk);
    chk("off", {chan_output_pin, chan_compl_output}, 0);
    for (int i = 0; i < 7; i++) begin
      acc(1, 8'h20, 0); acc(1, 8'h18, rol[i]); acc(1, 8'h20, mode[i]);
      repeat (3) @(posedge mclk);
      base = ncap;
      repeat (2) begin
        chan_filtered_input <= 1'b1;
        repeat (4) @(posedge mclk);
        if (mode[i][0]) chk("level", input_level, !(mode[i][1] & !mode[i][3]));
        chan_filtered_input <= 1'b0;
        repeat (4) @(posedge mclk);
      end
      chk("captures", ncap - base, ncx[i]);
    end
    acc(1, 8'h18, 0); acc(0, 8'h18, 0); chk("role_lock", q, 32'h0000_0001);
    wrap_up;
  end
endmodule // timer_channel_polarity_counter_test
